// ### uhpss_defines.svh
`ifndef UHPSS_DEFINES_SVH
`define UHPSS_DEFINES_SVH

// Clock rate and sequence intervals, all times in microseconds.
`define UHPSS_CLK_MHZ        100
`define UHPSS_T_FSDET_US     7000
`define UHPSS_T_TERM_US      50000
`define UHPSS_T_RSTCMP_US    150
`define UHPSS_T_SOFHS_MIN_US 120
`define UHPSS_T_SOFHS_MAX_US 130
`define UHPSS_T_SOFFS_MIN_US 900
`define UHPSS_T_SOFFS_MAX_US 1100
`define UHPSS_T_SUSP_US      5000

// Register byte offsets.
`define UHPSS_OFS_CMD   8'h00
`define UHPSS_OFS_CFG   8'h04
`define UHPSS_OFS_STAT  8'h08
`define UHPSS_OFS_ISTAT 8'h0C
`define UHPSS_OFS_IMASK 8'h10

// Field positions.
`define UHPSS_CFG_SPD_LSB  0
`define UHPSS_CFG_RWK_BIT  2
`define UHPSS_ST_MON_LSB   0
`define UHPSS_ST_XCVR_LSB  2
`define UHPSS_ST_TERM_BIT  4
`define UHPSS_ST_OPM_LSB   5
`define UHPSS_ST_BUSY_BIT  7
`define UHPSS_ST_CHIRP_BIT 8
`define UHPSS_ST_DISC_BIT  9
`define UHPSS_ST_RWK_BIT   10
`define UHPSS_INT_RST_BIT  0
`define UHPSS_INT_SUS_BIT  1
`define UHPSS_INT_FRM_BIT  2

// Reset values.
`define UHPSS_INT_RST 3'h0
`define UHPSS_MASK_RST 3'h0

`endif

// ### uhpss_pkg.sv
package uhpss_pkg;

  typedef enum logic [1:0] {
    MON_IDLE  = 2'b00,
    MON_RESET = 2'b01,
    MON_OPER  = 2'b10,
    MON_SUSP  = 2'b11
  } uhpss_mon_t;

  typedef enum logic [1:0] {
    SPD_HS = 2'b00,
    SPD_FS = 2'b01,
    SPD_LS = 2'b10
  } uhpss_speed_t;

  typedef enum logic {
    TERM_HS = 1'b0,
    TERM_FS = 1'b1
  } uhpss_term_t;

  typedef enum logic [1:0] {
    OPM_NORMAL = 2'b00,
    OPM_PWRDN  = 2'b11
  } uhpss_opm_t;

  typedef enum logic [1:0] {
    CMD_NONE  = 2'b00,
    CMD_RESET = 2'b01,
    CMD_OPER  = 2'b10,
    CMD_SUSP  = 2'b11
  } uhpss_cmd_t;

  typedef enum logic [3:0] {
    SEQ_IDLE     = 4'b0000,
    SEQ_RST_DET  = 4'b0001,
    SEQ_RST_HS   = 4'b0010,
    SEQ_RST_TERM = 4'b0011,
    SEQ_RST_CMP  = 4'b0100,
    SEQ_OP_WAIT  = 4'b0101,
    SEQ_OP_RUN   = 4'b0110,
    SEQ_SUS_DRN  = 4'b0111,
    SEQ_SUS_PD   = 4'b1000,
    SEQ_SUS_WAIT = 4'b1001
  } uhpss_seq_t;

endpackage

// ### uhpss_sequencer.sv
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
// Operation
// - Reset command: RESET, HS selects, Normal, chirp on except for an LS port.
// - No chirp after 7.0ms: transceiver FS, chirp off.
// - Termination to FS after 50ms.
// - Reset done flag 150us after termination FS.
// - LS port: transceiver LS after 7.0ms.
// - Operational command: OPERATION, Normal, disconnect detect.
// - HS first frame 120us to 130us.
// - FS/LS first frame 0.9ms to 1.1ms.
// - Suspend command: SUSPEND, detectors off.
// - Suspend waits for transaction end.
// - HS suspend: FS selects, then PowerDown.
// - FS/LS suspend: only PowerDown, speeds kept.
// - 5ms after PowerDown: disconnect detect, done flag.
// - Remote wake detect only if accepted.
`include "uhpss_defines.svh"

module uhpss_sequencer #(
  parameter int unsigned FSDET_CYC  = `UHPSS_T_FSDET_US * `UHPSS_CLK_MHZ + 1,
  parameter int unsigned TERM_CYC   = `UHPSS_T_TERM_US * `UHPSS_CLK_MHZ + 1,
  parameter int unsigned RSTCMP_CYC = `UHPSS_T_RSTCMP_US * `UHPSS_CLK_MHZ + 1,
  parameter int unsigned SOFHS_CYC  =
    (`UHPSS_T_SOFHS_MIN_US + `UHPSS_T_SOFHS_MAX_US) * `UHPSS_CLK_MHZ / 2,
  parameter int unsigned SOFFS_CYC  =
    (`UHPSS_T_SOFFS_MIN_US + `UHPSS_T_SOFFS_MAX_US) * `UHPSS_CLK_MHZ / 2,
  parameter int unsigned SUSP_CYC   = `UHPSS_T_SUSP_US * `UHPSS_CLK_MHZ + 1
) (
  input  wire logic        pclk,                  // System clock.
  input  wire logic        presetn,               // Async reset, low.
  input  wire logic        psel,                  // APB select.
  input  wire logic        penable,               // APB enable.
  input  wire logic        pwrite,                // APB write.
  input  wire logic [7:0]  paddr,                 // APB byte address.
  input  wire logic [31:0] pwdata,                // APB write data.
  output logic      [31:0] prdata,                // APB read data.
  output logic             pready,                // APB ready.
  output logic             pslverr,               // APB error.
  input  wire logic        chirp_seen,            // Device chirp, line.
  input  wire logic        bus_busy,              // Transaction running.
  output logic      [1:0]  host_state_monitor,    // Host state.
  output logic      [1:0]  transceiver_speed_sel, // Transceiver speed.
  output logic             termination_sel,       // Termination, 1 FS.
  output logic      [1:0]  phy_operating_mode,    // PHY mode.
  output logic             chirp_det_en,          // Chirp detect on.
  output logic             disc_det_en,           // Disconnect detect on.
  output logic             rwake_det_en,          // Remote wake detect on.
  output logic             frame_start,           // First SOF/KeepAlive.
  output logic             irq                    // Interrupt, level.
);

  // Sequencer state, configuration and the interval timer.
  uhpss_pkg::uhpss_seq_t   seq;
  uhpss_pkg::uhpss_speed_t attached_port_speed;
  logic                    remote_wake_accept_en;
  logic [31:0]             tmr;
  logic                    chirp_m;
  logic                    chirp_s;
  logic                    cmd_pulse;
  uhpss_pkg::uhpss_cmd_t   cmd_code;
  logic                    spd_hw_fs;
  logic [2:0]              ev;
  // Event flags and their mask.
  logic [2:0]              int_stat;
  logic [2:0]              int_mask;
  logic [2:0]              next_int_stat;
  // Handshake and read path of the register bus.
  logic                    acc;
  logic                    wr;
  logic                    hit;
  logic [31:0]             rdata;
  logic [31:0]             sof_cyc;

  // An APB request is taken at the first access edge, with pready low; a write lands with pready high.
  assign acc = psel && penable && !pready;
  assign wr  = psel && penable && pready && pwrite;

  // The first frame delay depends on the attached port speed.
  assign sof_cyc = (attached_port_speed == uhpss_pkg::SPD_HS) ? SOFHS_CYC
                                                              : SOFFS_CYC;

  // Two stage synchroniser for the chirp line from the transceiver.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chirp_m <= 1'b0;
      chirp_s <= 1'b0;
    end else begin
      chirp_m <= chirp_seen;
      chirp_s <= chirp_m;
    end
  end

  // Read multiplexer and address decode.
  always_comb begin
    rdata = 32'h0;
    hit   = 1'b1;
    unique case (paddr)
      `UHPSS_OFS_CMD: begin
        rdata[1:0] = cmd_code;
      end
      `UHPSS_OFS_CFG: begin
        rdata[`UHPSS_CFG_SPD_LSB +: 2] = attached_port_speed;
        rdata[`UHPSS_CFG_RWK_BIT]      = remote_wake_accept_en;
      end
      `UHPSS_OFS_STAT: begin
        rdata[`UHPSS_ST_MON_LSB +: 2]  = host_state_monitor;
        rdata[`UHPSS_ST_XCVR_LSB +: 2] = transceiver_speed_sel;
        rdata[`UHPSS_ST_TERM_BIT]      = termination_sel;
        rdata[`UHPSS_ST_OPM_LSB +: 2]  = phy_operating_mode;
        rdata[`UHPSS_ST_BUSY_BIT]      = (seq != uhpss_pkg::SEQ_IDLE) &&
                                         (seq != uhpss_pkg::SEQ_OP_RUN);
        rdata[`UHPSS_ST_CHIRP_BIT]     = chirp_det_en;
        rdata[`UHPSS_ST_DISC_BIT]      = disc_det_en;
        rdata[`UHPSS_ST_RWK_BIT]       = rwake_det_en;
      end
      `UHPSS_OFS_ISTAT: begin
        rdata[2:0] = int_stat;
      end
      `UHPSS_OFS_IMASK: begin
        rdata[2:0] = int_mask;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // APB answer: one wait state, read data and error held with pready.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= acc;
      pslverr <= acc && !hit;
      prdata  <= (acc && !pwrite) ? rdata : 32'h0;
    end
  end

  // Command register: a write of a nonzero code starts a sequence.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_pulse <= 1'b0;
      cmd_code  <= uhpss_pkg::CMD_NONE;
    end else begin
      cmd_pulse <= 1'b0;
      if (wr && paddr == `UHPSS_OFS_CMD && pwdata[1:0] != 2'h0) begin
        cmd_pulse <= 1'b1;
        cmd_code  <= uhpss_pkg::uhpss_cmd_t'(pwdata[1:0]);
      end
    end
  end

  // Configuration and mask; the hardware speed update wins over a write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      attached_port_speed   <= uhpss_pkg::SPD_HS;
      remote_wake_accept_en <= 1'b0;
      int_mask              <= `UHPSS_MASK_RST;
    end else begin
      if (wr && paddr == `UHPSS_OFS_CFG) begin
        attached_port_speed   <= uhpss_pkg::uhpss_speed_t'(
                                   pwdata[`UHPSS_CFG_SPD_LSB +: 2]);
        remote_wake_accept_en <= pwdata[`UHPSS_CFG_RWK_BIT];
      end
      // The mask decides which flags may drive the interrupt line.
      if (wr && paddr == `UHPSS_OFS_IMASK) begin
        int_mask <= pwdata[2:0];
      end
      if (spd_hw_fs) begin
        attached_port_speed <= uhpss_pkg::SPD_FS;
      end
    end
  end

  // Sticky event flags, write one to clear; a new event beats the clear.
  always_comb begin
    next_int_stat = int_stat;
    if (wr && paddr == `UHPSS_OFS_ISTAT) begin
      next_int_stat = int_stat & ~pwdata[2:0];
    end
    next_int_stat = next_int_stat | ev;
  end

  // Flag register and interrupt line.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat <= `UHPSS_INT_RST;
      irq      <= 1'b0;
    end else begin
      int_stat <= next_int_stat;
      irq      <= |(next_int_stat & int_mask);
    end
  end

  // Port state sequencer with its interval counter and transceiver controls.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq                   <= uhpss_pkg::SEQ_IDLE;
      host_state_monitor    <= uhpss_pkg::MON_IDLE;
      transceiver_speed_sel <= uhpss_pkg::SPD_FS;
      termination_sel       <= uhpss_pkg::TERM_FS;
      phy_operating_mode    <= uhpss_pkg::OPM_NORMAL;
      chirp_det_en          <= 1'b0;
      disc_det_en           <= 1'b0;
      rwake_det_en          <= 1'b0;
      frame_start           <= 1'b0;
      spd_hw_fs             <= 1'b0;
      ev                    <= 3'h0;
      tmr                   <= 32'h0;
    end else begin
      // Pulses last one cycle unless a step below raises them again.
      frame_start <= 1'b0;
      spd_hw_fs   <= 1'b0;
      ev          <= 3'h0;
      // The interval timer saturates so that a long rest never wraps it.
      if (tmr != 32'hFFFFFFFF) begin
        tmr <= tmr + 32'h1;
      end
      // A command restarts the timer and aborts any running sequence.
      if (cmd_pulse) begin
        tmr <= 32'h0;
        unique case (cmd_code)
          // Reset entry: high speed selects, Normal mode and, except for an LS port, the chirp watch.
          uhpss_pkg::CMD_RESET: begin
            host_state_monitor    <= uhpss_pkg::MON_RESET;
            transceiver_speed_sel <= uhpss_pkg::SPD_HS;
            termination_sel       <= uhpss_pkg::TERM_HS;
            phy_operating_mode    <= uhpss_pkg::OPM_NORMAL;
            // An LS port skips the chirp step altogether.
            chirp_det_en <= (attached_port_speed != uhpss_pkg::SPD_LS);
            seq          <= uhpss_pkg::SEQ_RST_DET;
          end
          // Operation entry: transactions may run and disconnect watch is on.
          uhpss_pkg::CMD_OPER: begin
            host_state_monitor <= uhpss_pkg::MON_OPER;
            phy_operating_mode <= uhpss_pkg::OPM_NORMAL;
            disc_det_en        <= 1'b1;
            chirp_det_en       <= 1'b0;
            seq                <= uhpss_pkg::SEQ_OP_WAIT;
          end
          // Suspend entry: both detectors stay off until the sequence ends.
          uhpss_pkg::CMD_SUSP: begin
            host_state_monitor <= uhpss_pkg::MON_SUSP;
            disc_det_en        <= 1'b0;
            rwake_det_en       <= 1'b0;
            chirp_det_en       <= 1'b0;
            seq                <= uhpss_pkg::SEQ_SUS_DRN;
          end
          // A zero code never pulses; this item only completes the case.
          uhpss_pkg::CMD_NONE: begin
            seq <= seq;
          end
        endcase
      end else begin
        // Between commands the stored state walks through its timed steps.
        unique case (seq)
          // Resting states hold until the next command arrives.
          uhpss_pkg::SEQ_IDLE,
          uhpss_pkg::SEQ_RST_HS,
          uhpss_pkg::SEQ_OP_RUN: begin
            seq <= seq;
          end
          // A chirp hands the port to the high speed handshake.
          uhpss_pkg::SEQ_RST_DET: begin
            if (chirp_det_en && chirp_s) begin
              seq <= uhpss_pkg::SEQ_RST_HS;
            end else if (tmr >= FSDET_CYC) begin
              // An LS port goes straight to its own transceiver speed.
              if (attached_port_speed == uhpss_pkg::SPD_LS) begin
                transceiver_speed_sel <= uhpss_pkg::SPD_LS;
              end else begin
                transceiver_speed_sel <= uhpss_pkg::SPD_FS;
                spd_hw_fs             <= 1'b1;
                chirp_det_en          <= 1'b0;
              end
              seq <= uhpss_pkg::SEQ_RST_TERM;
            end
          end
          // Reset length counts from the command, not from the speed switch.
          uhpss_pkg::SEQ_RST_TERM: begin
            if (tmr >= TERM_CYC) begin
              termination_sel <= uhpss_pkg::TERM_FS;
              tmr             <= 32'h0;
              seq             <= uhpss_pkg::SEQ_RST_CMP;
            end
          end
          // The done flag counts from the termination switch.
          uhpss_pkg::SEQ_RST_CMP: begin
            if (tmr >= RSTCMP_CYC) begin
              ev[`UHPSS_INT_RST_BIT] <= 1'b1;
              seq                    <= uhpss_pkg::SEQ_IDLE;
            end
          end
          // Firmware must start operation early enough after a reset.
          uhpss_pkg::SEQ_OP_WAIT: begin
            if (tmr >= sof_cyc) begin
              frame_start            <= 1'b1;
              ev[`UHPSS_INT_FRM_BIT] <= 1'b1;
              seq                    <= uhpss_pkg::SEQ_OP_RUN;
            end
          end
          // Nothing changes on the transceiver until the bus is quiet.
          uhpss_pkg::SEQ_SUS_DRN: begin
            if (!bus_busy) begin
              if (transceiver_speed_sel == uhpss_pkg::SPD_HS) begin
                transceiver_speed_sel <= uhpss_pkg::SPD_FS;
                termination_sel       <= uhpss_pkg::TERM_FS;
                seq                   <= uhpss_pkg::SEQ_SUS_PD;
              end else begin
                // FS and LS ports keep their selects and only power down.
                phy_operating_mode <= uhpss_pkg::OPM_PWRDN;
                tmr                <= 32'h0;
                seq                <= uhpss_pkg::SEQ_SUS_WAIT;
              end
            end
          end
          // One cycle after the FS selects the transceiver is powered down.
          uhpss_pkg::SEQ_SUS_PD: begin
            phy_operating_mode <= uhpss_pkg::OPM_PWRDN;
            tmr                <= 32'h0;
            seq                <= uhpss_pkg::SEQ_SUS_WAIT;
          end
          // The wake window counts from the PowerDown entry.
          uhpss_pkg::SEQ_SUS_WAIT: begin
            if (tmr >= SUSP_CYC) begin
              disc_det_en            <= 1'b1;
              rwake_det_en           <= remote_wake_accept_en;
              ev[`UHPSS_INT_SUS_BIT] <= 1'b1;
              seq                    <= uhpss_pkg::SEQ_IDLE;
            end
          end
          // An illegal code falls back to idle rather than locking up.
          default: begin
            seq <= uhpss_pkg::SEQ_IDLE;
          end
        endcase
      end
    end
  end

endmodule

// ### uhpss_far_end.sv
`timescale 1ns/1ps
module uhpss_far_end (
  input  wire logic       pclk,       // Clock.
  input  wire logic       presetn,    // Reset, low.
  input  wire logic       busy_go,    // Start a transaction.
  input  wire logic [4:0] busy_len,   // Its length in cycles.
  output logic            bus_busy,   // Transaction running.
  output logic            chirp_seen  // Device chirp.
);
  logic [4:0] left;

  // A started transaction counts down its length; a new busy_go reloads the count from busy_len.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left <= 5'h00;
    end else if (busy_go) begin
      left <= busy_len;
    end else if (left != 5'h00) begin
      left <= left - 5'h01;
    end
  end

  // The attached FS or LS device never chirps.
  assign bus_busy = (left != 5'h00);
  assign chirp_seen = 1'b0;
endmodule

// ### uhpss_sequencer_sva.sv
`timescale 1ns/1ps
module uhpss_sequencer_sva #(
  parameter int unsigned FSDET_CYC = 70,
  parameter int unsigned TERM_CYC  = 500,
  parameter int unsigned SOFHS_CYC = 12,
  parameter int unsigned SOFFS_CYC = 90,
  parameter int unsigned SUSP_CYC  = 50
) (
  input wire logic       pclk,                  // Clock.
  input wire logic       presetn,               // Reset, low.
  input wire logic       psel,                  // APB select.
  input wire logic       penable,               // APB enable.
  input wire logic       pwrite,                // APB write.
  input wire logic [7:0] paddr,                 // APB address.
  input wire logic       pready,                // APB ready.
  input wire logic       bus_busy,              // Transaction running.
  input wire logic [1:0] host_state_monitor,    // Host state.
  input wire logic [1:0] transceiver_speed_sel, // Transceiver speed.
  input wire logic       termination_sel,       // Termination.
  input wire logic [1:0] phy_operating_mode,    // PHY mode.
  input wire logic       chirp_det_en,          // Chirp detect.
  input wire logic       disc_det_en,           // Disconnect detect.
  input wire logic       rwake_det_en,          // Wake detect.
  input wire logic       frame_start            // First frame.
);
  int unsigned st_cnt;
  int unsigned pd_cnt;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Cycles since the last command write, and cycles spent in PowerDown.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_cnt <= 0;
      pd_cnt <= 0;
    end else begin
      st_cnt <= (psel && penable && pready && pwrite && paddr == 8'h00) ? 0 : st_cnt + 1;
      pd_cnt <= (phy_operating_mode == 2'h3) ? pd_cnt + 1 : 0;
    end
  end

  rst_entry_a: assert property ($changed(host_state_monitor) && host_state_monitor == 2'h1
    |-> !termination_sel && phy_operating_mode == 2'h0 && transceiver_speed_sel == 2'h0)
    else $error("reset entry selects wrong");
  speed_switch_a: assert property (host_state_monitor == 2'h1 &&
    $past(transceiver_speed_sel) == 2'h0 && transceiver_speed_sel != 2'h0
    |-> st_cnt >= FSDET_CYC && !chirp_det_en) else $error("speed switched early");
  term_fs_a: assert property ($rose(termination_sel) && host_state_monitor == 2'h1
    |-> st_cnt >= TERM_CYC) else $error("termination switched early");
  oper_entry_a: assert property ($changed(host_state_monitor) && host_state_monitor == 2'h2
    |-> phy_operating_mode == 2'h0 && disc_det_en) else $error("operation entry wrong");
  frame_win_a: assert property (frame_start |-> host_state_monitor == 2'h2 &&
    ((st_cnt >= SOFHS_CYC && st_cnt <= SOFHS_CYC + 4) ||
     (st_cnt >= SOFFS_CYC && st_cnt <= SOFFS_CYC + 4))) else $error("first frame off time");
  susp_entry_a: assert property ($changed(host_state_monitor) && host_state_monitor == 2'h3
    |-> !disc_det_en && !rwake_det_en) else $error("suspend entry detectors on");
  pd_wait_a: assert property ($rose(phy_operating_mode == 2'h3) |-> !$past(bus_busy))
    else $error("powerdown during transaction");
  susp_sel_a: assert property (host_state_monitor == 2'h3
    && $changed(transceiver_speed_sel) |-> transceiver_speed_sel == 2'h1 &&
    phy_operating_mode == 2'h0) else $error("suspend speed");
  wake_done_a: assert property ($rose(disc_det_en) && host_state_monitor == 2'h3
    |-> pd_cnt >= SUSP_CYC) else $error("suspend done early");
  rwake_en_a: assert property ($rose(rwake_det_en) |-> disc_det_en && pd_cnt >= SUSP_CYC)
    else $error("wake detect early");
endmodule

bind uhpss_sequencer uhpss_sequencer_sva #(.FSDET_CYC(FSDET_CYC), .TERM_CYC(TERM_CYC),
  .SOFHS_CYC(SOFHS_CYC), .SOFFS_CYC(SOFFS_CYC), .SUSP_CYC(SUSP_CYC)) i_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .bus_busy(bus_busy), .host_state_monitor(host_state_monitor),
  .transceiver_speed_sel(transceiver_speed_sel), .termination_sel(termination_sel),
  .phy_operating_mode(phy_operating_mode), .chirp_det_en(chirp_det_en),
  .disc_det_en(disc_det_en), .rwake_det_en(rwake_det_en), .frame_start(frame_start));

// ### tb_usb_host_port_state_sequencer.sv
`timescale 1ns/1ps
module tb_usb_host_port_state_sequencer;
  localparam int FD = 70, TM = 500, RC = 15, SH = 12, SF = 90, SU = 50;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, busy_go = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h0B0CBB03;
  logic [4:0]  busy_len = 5'h00;
  logic [1:0]  mon, xcvr, opm;
  logic        pready, pslverr, chirp, busy, term, chen, disc, rwk, frm, irq, err;
  int          mismatches = 0, compares = 0, cyc = 0, n = 0, exp_int = 0;

  uhpss_sequencer #(.FSDET_CYC(FD), .TERM_CYC(TM), .RSTCMP_CYC(RC), .SOFHS_CYC(SH),
    .SOFFS_CYC(SF), .SUSP_CYC(SU)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chirp_seen(chirp), .bus_busy(busy),
    .host_state_monitor(mon), .transceiver_speed_sel(xcvr), .termination_sel(term),
    .phy_operating_mode(opm), .chirp_det_en(chen), .disc_det_en(disc),
    .rwake_det_en(rwk), .frame_start(frm), .irq(irq));
  uhpss_far_end i_far (.pclk(pclk), .presetn(presetn), .busy_go(busy_go),
    .busy_len(busy_len), .bus_busy(busy), .chirp_seen(chirp));

  // Clock and a cycle ceiling that cuts a hang short.
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic win(int c, int m);
    return c >= m && c <= m + 4;
  endfunction
  function automatic logic cond(int k);
    case (k)
      0: return xcvr != 2'h0;
      1: return term;
      2: return irq;
      3: return frm;
      4: return opm == 2'h3;
      default: return disc;
    endcase
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // One APB transfer; setup, then access held until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t >= 50) mismatches++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // Counts edges until a condition holds, starting from c0.
  task automatic wait_on(input int k, input int c0);
    n = c0;
    do begin
      @(posedge pclk);
      n++;
    end while (cond(k) !== 1'b1 && n < 2000);
    if (n >= 2000) mismatches++;
  endtask
  // Suspend with a transaction running; xe is the expected speed afterwards.
  task automatic susp(input logic rk, input logic [1:0] xe);
    busy_len <= 5'd12 + 5'(xs() % 16);
    busy_go <= 1'b1;
    @(posedge pclk);
    busy_go <= 1'b0;
    wr(8'h00, 32'h3);
    repeat (3) @(posedge pclk);
    chk({mon, disc, rwk}, 4'hC);
    chk(opm, 2'h0);
    wait_on(4, 0);
    chk({xcvr, term}, {xe, 1'b1});
    wait_on(5, 0);
    chk(win(n, SU), 1'b1);
    chk(rwk, rk);
    rchk(8'h08, {rk, 3'h4, 2'h3, 1'b1, xe, 2'h3});
    exp_int |= 2;
    rchk(8'h0C, exp_int);
    wr(8'h0C, 32'h2);
    exp_int &= ~2;
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk({xcvr, term, opm, mon, irq}, 8'h60);
    rchk(8'h0C, 32'h0);
    rchk(8'h10, 32'h0);
    apb(1'b0, 8'h80 | 8'(xs() & 32'h7C), 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    // FS reset, command given twice so the timer restarts.
    wr(8'h10, 32'h7);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h1);
    repeat (20) @(posedge pclk);
    wr(8'h00, 32'h1);
    repeat (3) @(posedge pclk);
    chk({chen, mon, xcvr, term, opm}, 8'hA0);
    wait_on(0, 3);
    chk(win(n, FD), 1'b1);
    chk({xcvr, chen}, 3'h2);
    wait_on(1, n);
    chk(win(n, TM), 1'b1);
    wait_on(2, 0);
    chk(win(n, RC), 1'b1);
    exp_int |= 1;
    rchk(8'h0C, exp_int);
    rchk(8'h04, 32'h1);
    wr(8'h0C, 32'h1);
    exp_int &= ~1;
    repeat (3) @(posedge pclk);
    chk(irq, 1'b0);
    // FS operation, started promptly after the reset completes.
    wr(8'h00, 32'h2);
    repeat (3) @(posedge pclk);
    chk({mon, opm, disc}, 5'h11);
    wait_on(3, 3);
    chk(win(n, SF), 1'b1);
    exp_int |= 4;
    repeat (3) @(posedge pclk);
    chk(irq, 1'b1);
    // HS operation timing.
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h2);
    wait_on(3, 0);
    chk(win(n, SH), 1'b1);
    rchk(8'h0C, exp_int);
    wr(8'h0C, 32'h4);
    exp_int &= ~4;
    // HS suspend from the HS selects of a fresh reset.
    wr(8'h04, 32'h4);
    wr(8'h00, 32'h1);
    repeat (5) @(posedge pclk);
    susp(1'b1, 2'h1);
    // LS reset, then suspend with wake refused.
    wr(8'h04, 32'h2);
    wr(8'h00, 32'h1);
    repeat (3) @(posedge pclk);
    chk(chen, 1'b0);
    wait_on(0, 3);
    chk({xcvr, 1'(win(n, FD))}, 3'h5);
    wait_on(1, n);
    chk(win(n, TM), 1'b1);
    susp(1'b0, 2'h2);
    end_sim();
  end
endmodule
